// [rtl/pack_protection_config_regs.v]
// Protection configuration register slice with serial access
//
// Functional notes
// - Auto charge-OC off clear: OC switches FETs off
// - Charge OC always sets flag, powers temp supply
// - Threshold select codes map 0.10 to 0.16V
// - Short circuit persistence 190us or 10ms
// - Charge divider divides charge delay by 32
// - Discharge divider divides discharge delay by 64
// - Charge delay 80 to 640ms, 2.5-20ms divided
// - Auto scan powers temp sensing 5ms/640ms
// - Regulator disable bit turns internal regulator off
// - Temp supply force-on holds supply output on
// - External overtemp shutdown disable, flag still set
// - Internal overtemp shutdown disable, flag still set
// - Force reset bit clears all registers except the discharge config
// - Wake disable ignores the wake pin
// - Wake polarity picks rising or falling edge
// - Feature register writes need feature enable
// - Charge register writes need charge enable
// - Discharge register writes need discharge enable
// - Write enables come up as zero
// - Two user flags are free storage
// - Charge OC clears charge switch unless disabled
`timescale 1ns/10ps
`default_nettype none
`include "pack_prot_regs.vh"
module pack_protection_config_regs #(
  parameter [6:0] DEV_ADDR = 7'h28,
  parameter [25:0] OCC_BASE_CYC = `OCC_BASE_US * `CLK_MHZ,
  parameter [25:0] SC_SHORT_CYC = `SC_SHORT_US * `CLK_MHZ,
  parameter [25:0] SC_LONG_CYC = `SC_LONG_US * `CLK_MHZ,
  parameter [25:0] SCAN_PERIOD_CYC = `SCAN_PERIOD_US * `CLK_MHZ,
  parameter [25:0] SCAN_ON_CYC = `SCAN_ON_US * `CLK_MHZ
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Serial bus
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // Analog detector inputs
  input wire charge_oc_cmp_i,
  input wire short_cmp_i,
  input wire ext_overtemp_i,
  input wire int_overtemp_i,
  input wire wake_pin_i,
  // Discharge side
  input wire disch_flag_i,
  input wire [7:0] disch_rdata_i,
  output reg disch_wr_o,
  output reg [7:0] disch_wdata_o,
  output reg discharge_delay_divider_o,
  output reg short_trip_o,
  // Analog and power controls
  output reg [1:0] charge_oc_threshold_o,
  output reg charge_fet_o,
  output reg fet_off_o,
  output reg balance_off_o,
  output reg temp_sensor_supply_out_o,
  output reg regulator_disable_o,
  output reg wake_o
);
  localparam [25:0] ONE26 = 26'h1;
  localparam [25:0] OCC_DIV_CYC = OCC_BASE_CYC >> `OCC_DIV_SHIFT;

  // Register storage
  reg [7:0] chg_cfg_r;
  reg [7:0] feat_cfg_r;
  reg [7:0] wen_cfg_r;
  reg charge_switch_on_r;
  reg charge_overcurrent_flag_r;
  reg ext_overtemp_flag_r;
  reg int_overtemp_flag_r;
  reg soft_clr_r;
  reg wake_q_r;
  reg [25:0] scan_cnt_r;

  // Bus side
  wire bus_wr;
  wire [7:0] bus_addr;
  wire [7:0] bus_wdata;
  wire [7:0] bus_ptr;
  reg [7:0] rd_data;

  // Timer results
  wire occ_trip;
  wire sc_trip;
  reg [25:0] occ_limit;
  reg [25:0] sc_limit;

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;

  serial_reg_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .wr_o(bus_wr),
    .wr_addr_o(bus_addr),
    .wr_data_o(bus_wdata),
    .ptr_o(bus_ptr),
    .rd_data_i(rd_data)
  );

  // Delay selection
  always @* begin
    occ_limit = chg_cfg_r[`CHG_DIV] ? OCC_DIV_CYC : OCC_BASE_CYC;
    occ_limit = occ_limit << chg_cfg_r[`CHG_TIME_HI:`CHG_TIME_LO];
    sc_limit = chg_cfg_r[`SC_LONG] ? SC_LONG_CYC : SC_SHORT_CYC;
  end

  persist_timer #(
    .W(26)
  ) u_occ_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clr_i(soft_clr_r),
    .cond_i(charge_oc_cmp_i),
    .limit_i(occ_limit),
    .trip_o(occ_trip)
  );

  persist_timer #(
    .W(26)
  ) u_sc_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clr_i(soft_clr_r),
    .cond_i(short_cmp_i),
    .limit_i(sc_limit),
    .trip_o(sc_trip)
  );

  // Read decode by the pointer of the serial slave
  always @* begin
    if (bus_ptr == `ADDR_DISCH_CFG) begin
      rd_data = disch_rdata_i;
    end else if (bus_ptr == `ADDR_CHG_CFG) begin
      rd_data = chg_cfg_r;
    end else if (bus_ptr == `ADDR_FEAT_CFG) begin
      rd_data = feat_cfg_r;
    end else if (bus_ptr == `ADDR_WEN) begin
      rd_data = {wen_cfg_r[7:3], 3'h0};
    end else if (bus_ptr == `ADDR_FET_STAT) begin
      rd_data = {2'h0, charge_overcurrent_flag_r, ext_overtemp_flag_r,
                 int_overtemp_flag_r, 2'h0, charge_switch_on_r};
    end else begin
      rd_data = 8'h00;
    end
  end

  wire wr_disch = bus_wr && bus_addr == `ADDR_DISCH_CFG;
  wire wr_chg = bus_wr && bus_addr == `ADDR_CHG_CFG;
  wire wr_feat = bus_wr && bus_addr == `ADDR_FEAT_CFG;
  wire wr_wen = bus_wr && bus_addr == `ADDR_WEN;
  wire wr_stat = bus_wr && bus_addr == `ADDR_FET_STAT;
  wire auto_occ_off = occ_trip && !chg_cfg_r[`CHG_AUTO_OFF];
  wire ext_shut = ext_overtemp_i && !feat_cfg_r[`FEAT_XTSD_DIS];
  wire int_shut = int_overtemp_i && !feat_cfg_r[`FEAT_ITSD_DIS];
  wire scan_on = scan_cnt_r < SCAN_ON_CYC;
  wire wake_edge = feat_cfg_r[`FEAT_WAKE_POL] ? (wake_pin_i && !wake_q_r)
                                               : (!wake_pin_i && wake_q_r);

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chg_cfg_r <= `RST_BYTE;
      feat_cfg_r <= `RST_BYTE;
      wen_cfg_r <= `RST_BYTE;
      charge_switch_on_r <= 1'b0;
      charge_overcurrent_flag_r <= 1'b0;
      ext_overtemp_flag_r <= 1'b0;
      int_overtemp_flag_r <= 1'b0;
      soft_clr_r <= 1'b0;
      wake_q_r <= 1'b0;
      scan_cnt_r <= 26'h0;
      disch_wr_o <= 1'b0;
      disch_wdata_o <= 8'h00;
      discharge_delay_divider_o <= 1'b0;
      short_trip_o <= 1'b0;
      charge_oc_threshold_o <= 2'h0;
      charge_fet_o <= 1'b0;
      fet_off_o <= 1'b0;
      balance_off_o <= 1'b0;
      temp_sensor_supply_out_o <= 1'b0;
      regulator_disable_o <= 1'b0;
      wake_o <= 1'b0;
    end else if (soft_clr_r) begin
      // Forced reset takes one cycle, like a power-on clear
      chg_cfg_r <= `RST_BYTE;
      feat_cfg_r <= `RST_BYTE;
      wen_cfg_r <= `RST_BYTE;
      charge_switch_on_r <= 1'b0;
      charge_overcurrent_flag_r <= 1'b0;
      ext_overtemp_flag_r <= 1'b0;
      int_overtemp_flag_r <= 1'b0;
      soft_clr_r <= 1'b0;
      scan_cnt_r <= 26'h0;
      disch_wr_o <= 1'b0;
      disch_wdata_o <= 8'h00;
      discharge_delay_divider_o <= 1'b0;
      short_trip_o <= 1'b0;
      charge_oc_threshold_o <= 2'h0;
      charge_fet_o <= 1'b0;
      fet_off_o <= 1'b0;
      balance_off_o <= 1'b0;
      temp_sensor_supply_out_o <= 1'b0;
      regulator_disable_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      wake_q_r <= wake_pin_i;
      disch_wr_o <= 1'b0;
      // Software writes first; hardware events below override them
      if (wr_chg && wen_cfg_r[`WEN_CHG])
        chg_cfg_r <= bus_wdata;
      if (wr_feat && wen_cfg_r[`WEN_FEAT]) begin
        feat_cfg_r <= {bus_wdata[7:3], 1'b0, bus_wdata[1:0]};
        soft_clr_r <= bus_wdata[`FEAT_FORCE_RST];
      end
      if (wr_wen)
        wen_cfg_r <= {bus_wdata[7:3], 3'h0};
      if (wr_disch && wen_cfg_r[`WEN_DISCH]) begin
        disch_wr_o <= 1'b1;
        disch_wdata_o <= bus_wdata;
      end
      if (wr_stat)
        charge_switch_on_r <= bus_wdata[`STAT_CSW];
      // Flags are write-one-to-clear; a new event wins the same cycle
      if (occ_trip)
        charge_overcurrent_flag_r <= 1'b1;
      else if (wr_stat && bus_wdata[`STAT_COC])
        charge_overcurrent_flag_r <= 1'b0;
      if (ext_overtemp_i)
        ext_overtemp_flag_r <= 1'b1;
      else if (wr_stat && bus_wdata[`STAT_XOT])
        ext_overtemp_flag_r <= 1'b0;
      if (int_overtemp_i)
        int_overtemp_flag_r <= 1'b1;
      else if (wr_stat && bus_wdata[`STAT_IOT])
        int_overtemp_flag_r <= 1'b0;
      // Safety beats a concurrent software switch-on
      if (auto_occ_off || ext_shut || int_shut)
        charge_switch_on_r <= 1'b0;
      fet_off_o <= auto_occ_off || ext_shut || int_shut;
      balance_off_o <= ext_shut || int_shut;
      charge_fet_o <= charge_switch_on_r && !auto_occ_off && !ext_shut && !int_shut;
      short_trip_o <= sc_trip;
      // Free-running scan period
      if (scan_cnt_r == SCAN_PERIOD_CYC - ONE26)
        scan_cnt_r <= 26'h0;
      else
        scan_cnt_r <= scan_cnt_r + ONE26;
      temp_sensor_supply_out_o <= (scan_on && !feat_cfg_r[`FEAT_SCAN_OFF])
                                  || feat_cfg_r[`FEAT_TEMP_ON]
                                  || charge_overcurrent_flag_r || occ_trip
                                  || disch_flag_i;
      charge_oc_threshold_o <= chg_cfg_r[`CHG_THR_HI:`CHG_THR_LO];
      discharge_delay_divider_o <= chg_cfg_r[`DIS_DIV];
      regulator_disable_o <= feat_cfg_r[`FEAT_REG_DIS];
      wake_o <= wake_edge && !feat_cfg_r[`FEAT_WAKE_DIS];
    end
  end
endmodule // pack_protection_config_regs
`default_nettype wire

// [pkg/pack_prot_regs.vh]
// Offsets, field positions, reset values and timing for the protection config slice
`ifndef PACK_PROT_REGS_VH
`define PACK_PROT_REGS_VH
// Register offsets
`define ADDR_DISCH_CFG 8'h05
`define ADDR_CHG_CFG 8'h06
`define ADDR_FEAT_CFG 8'h07
`define ADDR_WEN 8'h08
`define ADDR_FET_STAT 8'h09
// Charge and time-scale config fields
`define CHG_AUTO_OFF 7
`define CHG_THR_HI 6
`define CHG_THR_LO 5
`define SC_LONG 4
`define CHG_DIV 3
`define DIS_DIV 2
`define CHG_TIME_HI 1
`define CHG_TIME_LO 0
// Feature config fields
`define FEAT_SCAN_OFF 7
`define FEAT_REG_DIS 6
`define FEAT_TEMP_ON 5
`define FEAT_XTSD_DIS 4
`define FEAT_ITSD_DIS 3
`define FEAT_FORCE_RST 2
`define FEAT_WAKE_DIS 1
`define FEAT_WAKE_POL 0
// Write-enable and user flag fields
`define WEN_FEAT 7
`define WEN_CHG 6
`define WEN_DISCH 5
`define UFLAG_HI 4
`define UFLAG_LO 3
// FET control and status fields
`define STAT_CSW 0
`define STAT_IOT 3
`define STAT_XOT 4
`define STAT_COC 5
// Reset values
`define RST_BYTE 8'h00
`define RST_WEN 5'h00
// Timing
`define CLK_MHZ 50
`define OCC_BASE_US 80000
`define OCC_DIV_SHIFT 5
`define SC_SHORT_US 190
`define SC_LONG_US 10000
`define SCAN_PERIOD_US 640000
`define SCAN_ON_US 5000
`endif

// [rtl/persist_timer.v]
// Condition persistence timer: one pulse once cond has held for limit cycles
`timescale 1ns/10ps
`default_nettype none
module persist_timer #(
  parameter W = 26
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  input wire clr_i,
  // Condition and length
  input wire cond_i,
  input wire [W-1:0] limit_i,
  // Result
  output reg trip_o
);
  localparam [W-1:0] ONE = 1;
  reg [W-1:0] cnt_r;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= {W{1'b0}};
      trip_o <= 1'b0;
    end else if (clr_i || !cond_i) begin
      cnt_r <= {W{1'b0}};
      trip_o <= 1'b0;
    end else begin
      // Saturates at limit so a held condition trips once only
      trip_o <= (cnt_r == limit_i - ONE);
      if (cnt_r != limit_i)
        cnt_r <= cnt_r + ONE;
    end
  end
endmodule // persist_timer
`default_nettype wire

// [rtl/serial_reg_slave.v]
// Two-wire serial slave with register pointer, byte writes and reads
`timescale 1ns/10ps
`default_nettype none
module serial_reg_slave #(
  parameter [6:0] DEV_ADDR = 7'h28
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Serial pins
  input wire scl_i,
  input wire sda_i,
  output reg sda_oe_o,
  // Register side
  output reg wr_o,
  output reg [7:0] wr_addr_o,
  output reg [7:0] wr_data_o,
  output reg [7:0] ptr_o,
  input wire [7:0] rd_data_i
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RX = 5'h02;
  localparam [4:0] S_ACK = 5'h04;
  localparam [4:0] S_TX = 5'h08;
  localparam [4:0] S_TACK = 5'h10;
  reg [4:0] st_r;
  reg [7:0] sh_r;
  reg [3:0] cnt_r;
  reg scl_q_r;
  reg sda_q_r;
  reg adr_ph_r;
  reg ptr_ph_r;
  reg rw_r;
  wire start_w = scl_i && scl_q_r && sda_q_r && !sda_i;
  wire stop_w = scl_i && scl_q_r && !sda_q_r && sda_i;
  wire rise_w = scl_i && !scl_q_r;
  wire fall_w = !scl_i && scl_q_r;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= S_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      adr_ph_r <= 1'b0;
      ptr_ph_r <= 1'b0;
      rw_r <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
      ptr_o <= 8'h00;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      wr_o <= 1'b0;
      if (start_w) begin
        st_r <= S_RX;
        cnt_r <= 4'h0;
        adr_ph_r <= 1'b1;
        sda_oe_o <= 1'b0;
      end else if (stop_w) begin
        st_r <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_r)
          S_RX: begin
            if (rise_w) begin
              sh_r <= {sh_r[6:0], sda_i};
              cnt_r <= cnt_r + 4'h1;
            end else if (fall_w && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (adr_ph_r) begin
                // Other addresses are left alone until the next start
                if (sh_r[7:1] == DEV_ADDR) begin
                  sda_oe_o <= 1'b1;
                  rw_r <= sh_r[0];
                  adr_ph_r <= 1'b0;
                  ptr_ph_r <= 1'b1;
                  st_r <= S_ACK;
                end else begin
                  st_r <= S_IDLE;
                end
              end else if (ptr_ph_r) begin
                ptr_o <= sh_r;
                ptr_ph_r <= 1'b0;
                sda_oe_o <= 1'b1;
                st_r <= S_ACK;
              end else begin
                wr_o <= 1'b1;
                wr_addr_o <= ptr_o;
                wr_data_o <= sh_r;
                ptr_o <= ptr_o + 8'h01;
                sda_oe_o <= 1'b1;
                st_r <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (fall_w) begin
              if (rw_r) begin
                sh_r <= rd_data_i;
                sda_oe_o <= !rd_data_i[7];
                ptr_o <= ptr_o + 8'h01;
                cnt_r <= 4'h1;
                st_r <= S_TX;
              end else begin
                sda_oe_o <= 1'b0;
                st_r <= S_RX;
              end
            end
          end
          S_TX: begin
            if (fall_w) begin
              if (cnt_r == 4'h8) begin
                sda_oe_o <= 1'b0;
                st_r <= S_TACK;
              end else begin
                sda_oe_o <= !sh_r[6];
                sh_r <= {sh_r[6:0], 1'b0};
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          S_TACK: begin
            if (rise_w)
              st_r <= sda_i ? S_IDLE : S_ACK;
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule // serial_reg_slave
`default_nettype wire

// [verification/pack_prot_checker_properties.sv]
// Port-level properties of the protection config slice
`timescale 1ns/10ps
`default_nettype none
module pack_prot_checker #(
  parameter [25:0] OCC_BASE_CYC = 26'd4000000
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Inputs seen
  input wire logic scl_i,
  input wire logic charge_oc_cmp_i,
  input wire logic short_cmp_i,
  input wire logic ext_overtemp_i,
  input wire logic int_overtemp_i,
  input wire logic wake_pin_i,
  // Outputs seen
  input wire logic sda_oe_o,
  input wire logic disch_wr_o,
  input wire logic short_trip_o,
  input wire logic [1:0] charge_oc_threshold_o,
  input wire logic charge_fet_o,
  input wire logic fet_off_o,
  input wire logic balance_off_o,
  input wire logic temp_sensor_supply_out_o,
  input wire logic regulator_disable_o,
  input wire logic wake_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Saturates so a stuck comparator never wraps
  logic [25:0] oc_cnt_r;
  always @(posedge core_clk_i or posedge rst_i)
    if (rst_i) oc_cnt_r <= 26'h0;
    else if (!charge_oc_cmp_i) oc_cnt_r <= 26'h0;
    else if (oc_cnt_r != 26'h3FFFFFF) oc_cnt_r <= oc_cnt_r + 26'h1;
  property p_reset_quiet;
    $past(rst_i) |-> !(sda_oe_o | charge_fet_o | fet_off_o | balance_off_o |
      regulator_disable_o | temp_sensor_supply_out_o | wake_o);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet");
  property p_oc_supply;
    oc_cnt_r > OCC_BASE_CYC * 8 + 8 |-> temp_sensor_supply_out_o;
  endproperty
  a_oc_supply: assert property (p_oc_supply) else $error("supply off after trip");
  property p_fetoff_cause;
    fet_off_o |-> $past(charge_oc_cmp_i, 2) || $past(charge_oc_cmp_i, 3) ||
      $past(ext_overtemp_i) || $past(int_overtemp_i) ||
      $past(ext_overtemp_i, 2) || $past(int_overtemp_i, 2);
  endproperty
  a_fetoff_cause: assert property (p_fetoff_cause) else $error("fet off uncaused");
  property p_ot_balance;
    balance_off_o |-> $past(ext_overtemp_i) || $past(int_overtemp_i) ||
      $past(ext_overtemp_i, 2) || $past(int_overtemp_i, 2);
  endproperty
  a_ot_balance: assert property (p_ot_balance) else $error("balance off uncaused");
  property p_short_pulse;
    short_trip_o |-> ($past(short_cmp_i, 2) && $past(short_cmp_i, 16)) ##1 !short_trip_o;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short trip bad");
  property p_dwr_pulse;
    disch_wr_o |-> !$past(scl_i) ##1 !disch_wr_o;
  endproperty
  a_dwr_pulse: assert property (p_dwr_pulse) else $error("discharge write bad");
  property p_wake_edge;
    wake_o |-> ($past(wake_pin_i) != $past(wake_pin_i, 2)) ||
      ($past(wake_pin_i, 2) != $past(wake_pin_i, 3));
  endproperty
  a_wake_edge: assert property (p_wake_edge) else $error("wake without edge");
  property p_thr_write;
    $changed(charge_oc_threshold_o) |-> !$past(scl_i, 2);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold moved");
endmodule // pack_prot_checker
bind pack_protection_config_regs pack_prot_checker #(.OCC_BASE_CYC(OCC_BASE_CYC))
  u_pack_prot_checker (.core_clk_i, .rst_i, .scl_i, .charge_oc_cmp_i, .short_cmp_i,
  .ext_overtemp_i, .int_overtemp_i, .wake_pin_i, .sda_oe_o, .disch_wr_o, .short_trip_o,
  .charge_oc_threshold_o, .charge_fet_o, .fet_off_o, .balance_off_o,
  .temp_sensor_supply_out_o, .regulator_disable_o, .wake_o);
`default_nettype wire

// [verification/serial_host_model.sv]
// Two-wire bus master standing in for the pack microcontroller
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  // Clock and bus
  input wire logic core_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // Phases of 4 clocks keep clear of the 3-clock minimum
  task automatic bit_io(input logic b, output logic s);
    tk(1); sda_low_o = !b; tk(3); scl_o = 1'b1; tk(2); s = sda_i; tk(2); scl_o = 1'b0;
  endtask
  task automatic start;
    sda_low_o = 1'b0; tk(4); scl_o = 1'b1; tk(4); sda_low_o = 1'b1; tk(4); scl_o = 1'b0;
  endtask
  task automatic stop;
    tk(1); sda_low_o = 1'b1; tk(3); scl_o = 1'b1; tk(4); sda_low_o = 1'b0; tk(4);
  endtask
  task automatic put(input logic [7:0] d, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ok = ok & !s;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    ok = 1'b1; start; put(8'h50, ok); put(a, ok); put(d, ok); stop;
  endtask
  // Single-byte read ends with a NACK
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic ok;
    logic s;
    ok = 1'b1; start; put(8'h50, ok); put(a, ok); start; put(8'h51, ok);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, s); stop;
  endtask
endmodule // serial_host_model
`default_nettype wire

// [verification/pack_protection_config_regs_tb.sv]
// Self-checking bench for the protection config slice
`timescale 1ns/10ps
`default_nettype none
module pack_protection_config_regs_tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic oc = 1'b0, sc = 1'b0, ext_overtemp_flag = 1'b0, int_overtemp_flag = 1'b0, wk = 1'b0, dfl = 1'b0;
  logic scl, sda_low, sda_w, sda_o, sda_oe, dwr, ddiv, strip, charge_switch_on, foff, boff, tsup, rdis, wake;
  logic [7:0] dwd;
  logic [7:0] drd = 8'hC3;
  logic [1:0] thr;
  int n_fail = 0, compares = 0, cyc = 0, nwake = 0, ndwr = 0, n, lim;
  always #10 core_clk_i = ~core_clk_i;
  assign sda_w = (sda_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  serial_host_model u_serial_host_model (.core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(sda_low));
  pack_protection_config_regs #(.OCC_BASE_CYC(26'd320), .SC_SHORT_CYC(26'd19),
    .SC_LONG_CYC(26'd100), .SCAN_PERIOD_CYC(26'd256), .SCAN_ON_CYC(26'd4))
    u_pack_protection_config_regs (.core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .charge_oc_cmp_i(oc), .short_cmp_i(sc),
    .ext_overtemp_i(ext_overtemp_flag), .int_overtemp_i(int_overtemp_flag), .wake_pin_i(wk), .disch_flag_i(dfl),
    .disch_rdata_i(drd), .disch_wr_o(dwr), .disch_wdata_o(dwd),
    .discharge_delay_divider_o(ddiv), .short_trip_o(strip), .charge_oc_threshold_o(thr),
    .charge_fet_o(charge_switch_on), .fet_off_o(foff), .balance_off_o(boff),
    .temp_sensor_supply_out_o(tsup), .regulator_disable_o(rdis), .wake_o(wake));
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Ceiling well above the roughly 22000 cycles the sequence needs
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) nwake <= nwake + 1;
    if (dwr === 1'b1) ndwr <= ndwr + 1;
    if (cyc == 80000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic tk(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmpr(input string nm, input int lo, input int hi, input int g);
    compares++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_serial_host_model.write_reg(a, d, ok);
    cmp8("ack", 8'h01, {7'h0, ok});
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_serial_host_model.read_reg(a, d);
    cmp8("reg", e, d);
  endtask
  // Bounded wait on supply (w=0) or short trip (w=1)
  task automatic wait_hi(input int w, output int k);
    k = 0;
    while (k < 4000 && !(w == 0 ? tsup === 1'b1 : strip === 1'b1)) begin
      tk(1);
      k++;
    end
  endtask
  task automatic wake_try(input logic [7:0] f, input int e);
    wr(8'h07, f); tk(2); n = nwake;
    wk = !wk; tk(4); wk = !wk; tk(4);
    cmpr("wake", n + e, n + e, nwake);
  endtask
  initial begin
    tk(8); rst_i = 1'b0; tk(2);
    chk(8'h08, 8'h00);
    chk(8'h0A, 8'h00);
    wr(8'h06, 8'hA5); chk(8'h06, 8'h00);
    wr(8'h07, 8'h20); chk(8'h07, 8'h00);
    wr(8'h05, 8'h3C); cmp8("dwr", 8'h00, ndwr[7:0]);
    wr(8'h08, 8'hFF); chk(8'h08, 8'hF8);
    wr(8'h08, 8'hE0); chk(8'h08, 8'hE0);
    wr(8'h05, 8'h3C); cmp8("dwr", 8'h01, ndwr[7:0]);
    cmp8("dwd", 8'h3C, dwd); chk(8'h05, 8'hC3);
    drd = 8'h5A;
    chk(8'h05, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      wr(8'h06, {1'b0, i[1:0], 5'h04}); tk(3);
      cmp8("thr", {6'h0, i[1:0]}, {6'h0, thr});
      cmp8("ddiv", 8'h01, {7'h0, ddiv});
    end
    wr(8'h07, 8'hE0); tk(3); cmp8("rdis", 8'h01, {7'h0, rdis});
    n = 0; repeat (300) begin tk(1); n += (tsup === 1'b1); end
    cmpr("force", 300, 300, n);
    wr(8'h07, 8'h00); tk(2);
    n = 0; repeat (512) begin tk(1); n += (tsup === 1'b1); end
    cmpr("scan", 8, 8, n);
    wr(8'h07, 8'h80);
    for (int i = 0; i < 8; i++) begin
      wr(8'h06, {i == 7, 3'h0, i[2], 1'b0, i[1:0]}); wr(8'h09, 8'h21); tk(2);
      cmp8("charge_switch_on", 8'h01, {7'h0, charge_switch_on});
      lim = (320 << i[1:0]) >> (5 * i[2]);
      oc = 1'b1; wait_hi(0, n); cmpr("occ", lim, lim + 3, n);
      // Supply and FET-off pulse leave the same trip edge
      cmp8("foff", {7'h0, i != 7}, {7'h0, foff});
      chk(8'h09, {2'b00, 1'b1, 4'h0, i == 7}); oc = 1'b0;
      cmp8("charge_switch_on", {7'h0, i == 7}, {7'h0, charge_switch_on});
    end
    wr(8'h09, 8'h39); ext_overtemp_flag = 1'b1; tk(4); cmp8("boff", 8'h01, {7'h0, boff});
    cmp8("foff", 8'h01, {7'h0, foff});
    ext_overtemp_flag = 1'b0; chk(8'h09, 8'h10);
    wr(8'h07, 8'h98); wr(8'h09, 8'h39); int_overtemp_flag = 1'b1; tk(4);
    cmp8("foff", 8'h00, {7'h0, foff});
    cmp8("boff", 8'h00, {7'h0, boff}); int_overtemp_flag = 1'b0; chk(8'h09, 8'h09);
    // Scan off and charge flag clear, so only the discharge flag lights the supply
    dfl = 1'b1; tk(2); cmp8("dflag", 8'h01, {7'h0, tsup});
    dfl = 1'b0; tk(2); cmp8("dflag", 8'h00, {7'h0, tsup});
    for (int i = 0; i < 2; i++) begin
      wr(8'h06, {3'h0, i[0], 4'h0}); sc = 1'b1; wait_hi(1, n);
      lim = i ? 100 : 19; cmpr("short", lim, lim + 3, n); sc = 1'b0;
    end
    wake_try(8'h81, 1);
    wake_try(8'h80, 1);
    wake_try(8'h82, 0);
    wr(8'h07, 8'h84); tk(4);
    chk(8'h08, 8'h00); chk(8'h06, 8'h00);
    close_out();
  end
endmodule // pack_protection_config_regs_tb
`default_nettype wire
